/* hdl/sdtx_vpid_insert.sv */
// sdi transmit payload identifier inserter with valid cadence generator
`timescale 1ns/10ps
`include "sdtx_defs.svh"

module sdtx_vpid_insert (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire sdtx_pkg::sdtx_mode_type core_mode,
   input  wire logic [2:0]             std_select_in,
   input  wire logic                   insert_enable,
   input  wire logic                   overwrite_enable,
   input  wire logic [`SDTX_DW-1:0]    video_in,
   input  wire logic [`SDTX_LW-1:0]    video_in_b,
   input  wire logic                   video_valid_in,
   input  wire logic                   trs_marker,
   input  wire logic [`SDTX_LNW-1:0]   link_a_line_number_in,
   input  wire logic [`SDTX_LNW-1:0]   link_b_line_number_in,
   input  wire logic [`SDTX_LNW-1:0]   ident_line_field_zero,
   input  wire logic [`SDTX_LNW-1:0]   ident_line_field_one,
   input  wire logic [`SDTX_BW-1:0]    payload_ident_first_byte,
   input  wire logic [`SDTX_BW-1:0]    payload_ident_second_byte,
   input  wire logic [`SDTX_BW-1:0]    payload_ident_third_byte,
   input  wire logic [`SDTX_BW-1:0]    payload_ident_fourth_byte,
   input  wire logic [`SDTX_BW-1:0]    link_b_ident_first_byte,
   input  wire logic [`SDTX_BW-1:0]    link_b_ident_second_byte,
   input  wire logic [`SDTX_BW-1:0]    link_b_ident_third_byte,
   input  wire logic [`SDTX_BW-1:0]    link_b_ident_fourth_byte,
   output logic      [`SDTX_DW-1:0]    video_out_r,
   output logic      [`SDTX_LW-1:0]    video_out_b_r,
   output logic                        valid_out_r,
   output logic                        valid_out_b_r,
   output logic      [2:0]             std_out_r
);

   // ----------------------------------------------------------------
   // packet word helpers
   // ----------------------------------------------------------------

   // user word: even parity in bit 8, its inverse in bit 9
   function automatic logic [9:0] udw_word(input logic [7:0] b);
      udw_word = {~(^b), ^b, b};
   endfunction

   // word idx of the eleven-word identifier packet
   function automatic logic [9:0] pkt_word(input logic [3:0] idx,
                                           input logic [7:0] b1,
                                           input logic [7:0] b2,
                                           input logic [7:0] b3,
                                           input logic [7:0] b4);
      logic [8:0] sum;
      sum = 9'(`SDTX_DID) + 9'(`SDTX_SDID) + 9'(`SDTX_DC) + 9'(udw_word(b1))
            + 9'(udw_word(b2)) + 9'(udw_word(b3)) + 9'(udw_word(b4));
      unique case (idx)
         4'h0:    pkt_word = `SDTX_ADF0;
         4'h1:    pkt_word = `SDTX_ADF1;
         4'h2:    pkt_word = `SDTX_ADF1;
         4'h3:    pkt_word = `SDTX_DID;
         4'h4:    pkt_word = `SDTX_SDID;
         4'h5:    pkt_word = `SDTX_DC;
         4'h6:    pkt_word = udw_word(b1);
         4'h7:    pkt_word = udw_word(b2);
         4'h8:    pkt_word = udw_word(b3);
         4'h9:    pkt_word = udw_word(b4);
         default: pkt_word = {~sum[8], sum};
      endcase
   endfunction

   // ----------------------------------------------------------------
   // standard carried and cadence selection
   // ----------------------------------------------------------------
   logic [2:0]  std_sel;
   logic        has_b;
   logic        sd_now;
   logic        hd_half;
   logic [3:0]  cad_r;
   logic [3:0]  cad_last;
   logic        valid_nxt;

   // sd, hd and hd dual link configurations force their own code; the others, 3G included, follow the user select
   always_comb begin
      has_b = 1'b1;
      unique case (core_mode)
         sdtx_pkg::SDTX_SD_ONLY: begin
            std_sel = `SDTX_STD_SD;
            has_b   = 1'b0;
         end
         sdtx_pkg::SDTX_HD_ONLY: begin
            std_sel = `SDTX_STD_HD;
            has_b   = 1'b0;
         end
         sdtx_pkg::SDTX_HD_DUAL: std_sel = `SDTX_STD_HD;
         sdtx_pkg::SDTX_DUAL_RATE: begin
            std_sel = std_select_in;
            has_b   = 1'b0;
         end
         sdtx_pkg::SDTX_G3_ONLY,
         sdtx_pkg::SDTX_TRIPLE_RATE,
         sdtx_pkg::SDTX_MULTI_RATE: std_sel = std_select_in;
         default: begin
            std_sel = `SDTX_STD_SD;
            has_b   = 1'b0;
         end
      endcase
   end

   // hd inside a switchable core runs at half the word rate
   assign sd_now   = (std_sel == `SDTX_STD_SD) && (core_mode != sdtx_pkg::SDTX_G3_ONLY);
   assign hd_half  = (std_sel == `SDTX_STD_HD) && (core_mode == sdtx_pkg::SDTX_DUAL_RATE
                     || core_mode == sdtx_pkg::SDTX_TRIPLE_RATE
                     || core_mode == sdtx_pkg::SDTX_MULTI_RATE);
   assign cad_last = sd_now ? `SDTX_SD_LAST : `SDTX_HD_LAST;
   assign valid_nxt = sd_now ? (cad_r == 4'h0 || cad_r == `SDTX_SD_SECOND)
                    : hd_half ? (cad_r == 4'h0)
                    : 1'b1;

   // cadence counter; >= lets a standard change restart it cleanly
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cad_r <= 4'h0;
      end else if (cad_r >= cad_last) begin
         cad_r <= 4'h0;
      end else begin
         cad_r <= cad_r + 4'h1;
      end
   end

   // both strobes come from one term so they cannot drift apart
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         valid_out_r   <= 1'b1;
         valid_out_b_r <= 1'b1;
      end else begin
         valid_out_r   <= valid_nxt;
         valid_out_b_r <= (core_mode == sdtx_pkg::SDTX_HD_DUAL) && valid_nxt;
      end
   end

   // standard code toward the transceiver
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         std_out_r <= `SDTX_STD_SD;
      end else begin
         std_out_r <= std_sel;
      end
   end

   // ----------------------------------------------------------------
   // insertion sequencer
   // ----------------------------------------------------------------
   sdtx_pkg::sdtx_state_type st_r;
   logic [3:0]  pos_r;
   logic        trs_d_r;
   logic        ins_a_r;
   logic        ins_b_r;
   logic        trs_rise;
   logic [`SDTX_LNW-1:0] field_line;
   logic        hit_a;
   logic        hit_b;
   logic        present;
   logic        keep;
   logic        put;

   // xyz word carries the field and eav/sav flags in the luma lane
   assign trs_rise   = trs_marker && !trs_d_r;
   assign field_line = video_in[`SDTX_XYZ_F] ? ident_line_field_one : ident_line_field_zero;
   assign hit_a      = insert_enable && (link_a_line_number_in == field_line);
   assign hit_b      = insert_enable && has_b && (link_b_line_number_in == field_line);
   // a packet already in the stream starts with the first flag word
   assign present    = (video_in[19:10] == `SDTX_ADF0);
   assign keep       = (pos_r == 4'h0) && present && !overwrite_enable;
   assign put        = (st_r == sdtx_pkg::SDTX_INS) && video_valid_in && !keep;

   // edge of marker only: a two-cycle marker must not start two sequences
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         trs_d_r <= 1'b0;
      end else begin
         trs_d_r <= trs_marker;
      end
   end

   // words are counted on the valid strobe so the sd cadence is respected
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r    <= sdtx_pkg::SDTX_IDLE;
         pos_r   <= 4'h0;
         ins_a_r <= 1'b0;
         ins_b_r <= 1'b0;
      end else begin
         unique case (st_r)
            sdtx_pkg::SDTX_IDLE: begin
               if (trs_rise) begin
                  st_r  <= sdtx_pkg::SDTX_TRS;
                  pos_r <= 4'h1;
               end
            end
            sdtx_pkg::SDTX_TRS: begin
               if (video_valid_in && pos_r == `SDTX_XYZ_POS) begin
                  pos_r <= 4'h0;
                  if (video_in[`SDTX_XYZ_H] && (hit_a || hit_b)) begin
                     st_r    <= sdtx_pkg::SDTX_INS;
                     ins_a_r <= hit_a;
                     ins_b_r <= hit_b;
                  end else begin
                     st_r <= sdtx_pkg::SDTX_IDLE;
                  end
               end else if (video_valid_in) begin
                  pos_r <= pos_r + 4'h1;
               end
            end
            sdtx_pkg::SDTX_INS: begin
               if (video_valid_in && (keep || pos_r == `SDTX_PKT_LAST)) begin
                  st_r  <= sdtx_pkg::SDTX_IDLE;
                  pos_r <= 4'h0;
               end else if (video_valid_in) begin
                  pos_r <= pos_r + 4'h1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output data path
   // ----------------------------------------------------------------
   logic [`SDTX_DW-1:0] out_nxt;
   logic [`SDTX_LW-1:0] out_b_nxt;

   // unused lanes read as zero; link B rides dual link output or the chroma half
   always_comb begin
      if (core_mode == sdtx_pkg::SDTX_MULTI_RATE) begin
         out_nxt = video_in;
      end else begin
         out_nxt = {{(`SDTX_DW-`SDTX_LW){1'b0}}, video_in[`SDTX_LW-1:0]};
      end
      out_b_nxt = (core_mode == sdtx_pkg::SDTX_HD_DUAL) ? video_in_b : '0;
      if (put && ins_a_r) begin
         out_nxt[19:10] = pkt_word(pos_r, payload_ident_first_byte, payload_ident_second_byte,
                                   payload_ident_third_byte, payload_ident_fourth_byte);
      end
      if (put && ins_b_r && core_mode == sdtx_pkg::SDTX_HD_DUAL) begin
         out_b_nxt[19:10] = pkt_word(pos_r, link_b_ident_first_byte, link_b_ident_second_byte,
                                     link_b_ident_third_byte, link_b_ident_fourth_byte);
      end else if (put && ins_b_r) begin
         out_nxt[9:0] = pkt_word(pos_r, link_b_ident_first_byte, link_b_ident_second_byte,
                                 link_b_ident_third_byte, link_b_ident_fourth_byte);
      end
   end

   // one cycle of latency on the whole stream
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         video_out_r   <= '0;
         video_out_b_r <= '0;
      end else begin
         video_out_r   <= out_nxt;
         video_out_b_r <= out_b_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_sd_phase;
      sd_now |=> valid_out_r == ($past(cad_r) == 4'h0 || $past(cad_r) == 4'h5);
   endproperty
   a_sd_phase: assert property (p_sd_phase) else $error("sd valid phase wrong");

   property p_sd_wrap;
      sd_now && cad_r == 4'hA |=> cad_r == 4'h0;
   endproperty
   a_sd_wrap: assert property (p_sd_wrap) else $error("sd cadence period not eleven");

   property p_full_rate;
      !sd_now && !hd_half |=> valid_out_r;
   endproperty
   a_full_rate: assert property (p_full_rate) else $error("valid not held high");

   property p_hd_alt;
      (hd_half && !sys_rst) [*3] |-> valid_out_r != $past(valid_out_r);
   endproperty
   a_hd_alt: assert property (p_hd_alt) else $error("hd valid not alternating");

   property p_dual_b;
      core_mode == sdtx_pkg::SDTX_HD_DUAL |=> valid_out_b_r == valid_out_r;
   endproperty
   a_dual_b: assert property (p_dual_b) else $error("link b valid differs");

   property p_b_idle;
      core_mode != sdtx_pkg::SDTX_HD_DUAL |=> video_out_b_r == '0;
   endproperty
   a_b_idle: assert property (p_b_idle) else $error("link b output outside dual link");

   property p_lanes;
      core_mode != sdtx_pkg::SDTX_MULTI_RATE |=> video_out_r[`SDTX_DW-1:`SDTX_LW] == '0;
   endproperty
   a_lanes: assert property (p_lanes) else $error("upper lanes driven");

   property p_std_sd;
      core_mode == sdtx_pkg::SDTX_SD_ONLY |=> std_out_r == 3'h0;
   endproperty
   a_std_sd: assert property (p_std_sd) else $error("standard code wrong");

   property p_reset;
      disable iff (1'b0) sys_rst |=> valid_out_r && cad_r == 4'h0 && st_r == sdtx_pkg::SDTX_IDLE;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");

   property p_line;
      $rose(st_r == sdtx_pkg::SDTX_INS) |-> $past(hit_a || hit_b);
   endproperty
   a_line: assert property (p_line) else $error("insert on unmatched line");

   property p_keep;
      put == 1'b0 && st_r == sdtx_pkg::SDTX_INS && video_valid_in && keep
         |=> video_out_r[19:0] == $past(video_in[19:0]) && st_r == sdtx_pkg::SDTX_IDLE;
   endproperty
   a_keep: assert property (p_keep) else $error("existing identifier touched");

   property p_byte_a;
      put && ins_a_r && pos_r == 4'h6 |=> video_out_r[17:10] == $past(payload_ident_first_byte);
   endproperty
   a_byte_a: assert property (p_byte_a) else $error("link a byte one wrong");

   property p_byte_b;
      put && ins_b_r && pos_r == 4'h6 && core_mode == sdtx_pkg::SDTX_HD_DUAL
         |=> video_out_b_r[17:10] == $past(link_b_ident_first_byte);
   endproperty
   a_byte_b: assert property (p_byte_b) else $error("link b byte one wrong");

   c_sd_run:   cover property (sd_now [*8]);
   c_insert:   cover property (put && ins_a_r && pos_r == `SDTX_PKT_LAST);
   c_keep:     cover property (st_r == sdtx_pkg::SDTX_INS && video_valid_in && keep);
   c_dual_ins: cover property (put && ins_b_r && core_mode == sdtx_pkg::SDTX_HD_DUAL);

endmodule

/* hdl/sdtx_defs.svh */
// constants for the sdi transmit payload identifier inserter
//
// Notes on behaviour
// - SD single standard: valid strobe repeats one high, four low, one high, five low.
// - HD, 3G and HD dual link single standard: valid strobe held high.
// - dual rate: SD cadence for SD, one high one low for HD.
// - multi rate: SD cadence, HD alternating, 3G/6G/12G held high.
// - generated valid strobe may be looped back as the input valid.
// - HD dual link: link B valid strobe has identical timing to link A.
// - 20 bits per interface; link B output only in HD dual link.
// - user drives link B line number for 3G, dual link, triple, multi rate.
// - existing identifier replaced only while overwrite is asserted, else left untouched; only link A luma is checked, so one on link B alone is overwritten.
// - insertion enabled: four link A identifier bytes go into link A packet.
// - link B modes: four separate link B bytes go into link B.
// - output a 3-bit code of the standard being transmitted.
// - four 20-bit interfaces in multi rate mode, one otherwise.
`ifndef SDTX_DEFS_SVH
`define SDTX_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SDTX_LW        20
`define SDTX_DW        80
`define SDTX_LNW       11
`define SDTX_BW        8

// ----------------------------------------------------------------
// valid cadence counter
// ----------------------------------------------------------------
`define SDTX_SD_LAST   4'hA
`define SDTX_SD_SECOND 4'h5
`define SDTX_HD_LAST   4'h1

// ----------------------------------------------------------------
// standard codes
// ----------------------------------------------------------------
`define SDTX_STD_SD    3'h0
`define SDTX_STD_HD    3'h1
`define SDTX_STD_3GA   3'h3

// ----------------------------------------------------------------
// identifier packet words and timing reference positions
// ----------------------------------------------------------------
`define SDTX_ADF0      10'h000
`define SDTX_ADF1      10'h3FF
`define SDTX_DID       10'h241
`define SDTX_SDID      10'h101
`define SDTX_DC        10'h004
`define SDTX_PKT_LAST  4'hA
`define SDTX_XYZ_POS   4'h3
`define SDTX_XYZ_H     16
`define SDTX_XYZ_F     18

`endif

/* hdl/sdtx_pkg.sv */
// types for the sdi transmit payload identifier inserter
package sdtx_pkg;

   // ----------------------------------------------------------------
   // core configuration and insertion sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SDTX_SD_ONLY,
      SDTX_HD_ONLY,
      SDTX_G3_ONLY,
      SDTX_HD_DUAL,
      SDTX_DUAL_RATE,
      SDTX_TRIPLE_RATE,
      SDTX_MULTI_RATE
   } sdtx_mode_type;

   typedef enum logic [1:0] {
      SDTX_IDLE,
      SDTX_TRS,
      SDTX_INS
   } sdtx_state_type;

endpackage

/* testbench/sdtx_video_src.sv */
// user video source model: one timing reference sequence, then filler words
`timescale 1ns/10ps

module sdtx_video_src (
   input  wire logic        mclk,
   input  wire logic        go,
   input  wire logic [9:0]  xyz,
   input  wire logic [9:0]  first_luma,
   output logic             trs_marker,
   output logic [19:0]      word
);
   logic [4:0]  pos_r = 5'h00;
   logic        active_r = 1'b0;
   logic [31:0] filler_r = 32'h0;
   integer      fill_seed = 7;

   // ----------------------------------------------------------------
   // position in the sequence; filler changes every cycle so that a
   // stale word can never pass for the expected one
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      filler_r <= $random(fill_seed);
      if (go) begin
         active_r <= 1'b1;
         pos_r    <= 5'h00;
      end else if (active_r) begin
         pos_r <= pos_r + 5'h01;
         if (pos_r == 5'h14) active_r <= 1'b0;
      end
   end

   // marker on the first word only, one cycle long in these modes
   always_comb begin
      trs_marker = active_r && (pos_r == 5'h00);
      word       = filler_r[19:0];
      if (active_r) begin
         case (pos_r)
            5'h00:        word = 20'hFFFFF;
            5'h01, 5'h02: word = 20'h00000;
            5'h03:        word = {xyz, xyz};
            5'h04:        word = {first_luma, filler_r[9:0]};
            default:      word = filler_r[19:0];
         endcase
      end
   end
endmodule

/* testbench/tb_sdi_tx_payload_id_insert.sv */
// self-checking bench for the sdi transmit payload identifier inserter
`timescale 1ns/10ps
`include "sdtx_defs.svh"

module tb_sdi_tx_payload_id_insert;
   localparam logic [5:0] CAD_TAB [15] = '{6'h00, 6'h09, 6'h13, 6'h19, 6'h20, 6'h21, 6'h28, 6'h29,
                                           6'h2B, 6'h30, 6'h31, 6'h33, 6'h35, 6'h36, 6'h38};
   logic                    mclk;
   logic                    sys_rst;
   sdtx_pkg::sdtx_mode_type core_mode;
   logic [2:0]              std_sel;
   logic                    ins_en;
   logic                    ovw_en;
   logic                    go;
   logic [9:0]              xyz;
   logic [9:0]              first_luma;
   logic [59:0]             hi_r;
   logic [19:0]             vin_b;
   logic [10:0]             line_num;
   logic [31:0]             id_a;
   logic [31:0]             id_b;
   logic                    trs;
   logic [19:0]             src_word;
   logic [79:0]             vout;
   logic [19:0]             vout_b;
   logic                    vld;
   logic                    vld_b;
   logic [2:0]              std_out;
   integer                  seed;
   integer                  bad_count;
   integer                  tests_run;

   // ----------------------------------------------------------------
   // design and far side; valid is looped back from the generator
   // ----------------------------------------------------------------
   sdtx_vpid_insert sdtx_vpid_insert_i (
      .mclk                      (mclk),
      .sys_rst                   (sys_rst),
      .core_mode                 (core_mode),
      .std_select_in             (std_sel),
      .insert_enable             (ins_en),
      .overwrite_enable          (ovw_en),
      .video_in                  ({hi_r, src_word}),
      .video_in_b                (vin_b),
      .video_valid_in            (vld),
      .trs_marker                (trs),
      .link_a_line_number_in     (line_num),
      .link_b_line_number_in     (line_num),
      .ident_line_field_zero     (11'h00A),
      .ident_line_field_one      (11'h23F),
      .payload_ident_first_byte  (id_a[7:0]),
      .payload_ident_second_byte (id_a[15:8]),
      .payload_ident_third_byte  (id_a[23:16]),
      .payload_ident_fourth_byte (id_a[31:24]),
      .link_b_ident_first_byte   (id_b[7:0]),
      .link_b_ident_second_byte  (id_b[15:8]),
      .link_b_ident_third_byte   (id_b[23:16]),
      .link_b_ident_fourth_byte  (id_b[31:24]),
      .video_out_r               (vout),
      .video_out_b_r             (vout_b),
      .valid_out_r               (vld),
      .valid_out_b_r             (vld_b),
      .std_out_r                 (std_out)
   );

   sdtx_video_src sdtx_video_src_i (
      .mclk       (mclk),
      .go         (go),
      .xyz        (xyz),
      .first_luma (first_luma),
      .trs_marker (trs),
      .word       (src_word)
   );

   // ----------------------------------------------------------------
   // expectations
   // ----------------------------------------------------------------
   function automatic logic cad_exp(input logic [2:0] m, input logic [2:0] s, input int k);
      logic sd;
      sd = (m == 3'h0) || (m == 3'h7) || ((m >= 3'h4) && (s == 3'h0));
      if (sd) cad_exp = ((k % 11) == 0) || ((k % 11) == 5);
      else if ((m >= 3'h4) && (s == 3'h1)) cad_exp = ((k % 2) == 0);
      else cad_exp = 1'b1;
   endfunction

   // packet word n; the last word is the checksum over words 3 to 9
   function automatic logic [9:0] pw(input int n, input logic [31:0] by);
      logic [7:0] v;
      logic [8:0] sum;
      logic [9:0] t;
      sum = 9'h000;
      case (n)
         0: pw = 10'h000;
         1, 2: pw = 10'h3FF;
         3: pw = 10'h241;
         4: pw = 10'h101;
         5: pw = 10'h004;
         6, 7, 8, 9: begin
            v = by[8*(n-6) +: 8];
            pw = {~^v, ^v, v};
         end
         default: begin
            for (int i = 3; i < 10; i++) begin
               t = pw(i, by);
               sum = sum + t[8:0];
            end
            pw = {~sum[8], sum};
         end
      endcase
   endfunction

   task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // reset is held two edges; mode changes only under reset
   task automatic restart(input logic [2:0] m, input logic [2:0] s);
      @(posedge mclk);
      core_mode <= sdtx_pkg::sdtx_mode_type'(m);
      std_sel   <= s;
      sys_rst   <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst   <= 1'b0;
   endtask

   // random data with no marker: one cycle latency, unused lanes zero
   task automatic pass(input logic [2:0] m, input logic [2:0] s);
      logic [79:0] pin;
      logic [19:0] pin_b;
      logic [63:0] rnd;
      restart(m, s);
      for (int k = 0; k < 40; k++) begin
         @(posedge mclk);
         rnd = {$random(seed), $random(seed)};
         hi_r  <= rnd[59:0];
         vin_b <= rnd[63:44];
         #1;
         if (k > 0) chk("data out", vout, (m == 3'h6) ? pin : {60'h0, pin[19:0]});
         if (k > 0) chk("link b out", vout_b, (m == 3'h3) ? pin_b : 20'h0);
         pin   = {hi_r, src_word};
         pin_b = vin_b;
      end
   endtask

   // one timing reference; hit says whether the packet should replace data
   task automatic frame(input logic [2:0] m, input logic [9:0] x, input logic [9:0] fl, input logic ow,
                        input logic en, input logic [10:0] ln, input logic hit);
      logic [19:0] exp;
      logic [9:0]  bx;
      restart(m, (m == 3'h2) ? 3'h3 : 3'h1);
      id_a     <= $random(seed);
      id_b     <= $random(seed);
      ins_en   <= en;
      ovw_en   <= ow;
      xyz      <= x;
      first_luma <= fl;
      line_num <= ln;
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      for (int k = 0; k < 18; k++) begin
         #1;
         if (k > 0) chk("link a word", vout[19:0], exp);
         if (k > 0 && m == 3'h3) chk("link b luma", vout_b[19:10], bx);
         exp = src_word;
         bx  = vin_b[19:10];
         if (hit && k >= 4 && k <= 14) begin
            exp[19:10] = pw(k - 4, id_a);
            if (m == 3'h2) exp[9:0] = pw(k - 4, id_b);
            if (m == 3'h3) bx = pw(k - 4, id_b);
         end
         @(posedge mclk);
      end
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      #50000;
      bad_count++;
      results();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 26525;
      bad_count = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      core_mode = sdtx_pkg::SDTX_SD_ONLY;
      {std_sel, ins_en, ovw_en, go, xyz, first_luma, hi_r, vin_b, line_num, id_a, id_b} = '0;
      repeat (2) @(posedge mclk);
      foreach (CAD_TAB[i]) begin
         restart(CAD_TAB[i][5:3], CAD_TAB[i][2:0]);
         for (int k = 0; k < 23; k++) begin
            @(posedge mclk);
            #1;
            chk("valid", vld, cad_exp(CAD_TAB[i][5:3], CAD_TAB[i][2:0], k));
            chk("valid b", vld_b, (CAD_TAB[i][5:3] == 3'h3) ? cad_exp(3'h3, 3'h1, k) : 1'b0);
         end
      end
      restart(3'h2, 3'h0);
      for (int s = 0; s < 8; s++) begin
         std_sel <= s[2:0];
         repeat (3) @(posedge mclk);
         #1;
         chk("standard out", std_out, s[2:0]);
      end
      pass(3'h1, 3'h1);
      pass(3'h3, 3'h1);
      pass(3'h6, 3'h3);
      frame(3'h1, 10'h274, 10'h3A5, 1'b0, 1'b1, 11'h00A, 1'b1);
      frame(3'h3, 10'h274, 10'h3A5, 1'b0, 1'b1, 11'h00A, 1'b1);
      frame(3'h2, 10'h368, 10'h155, 1'b0, 1'b1, 11'h23F, 1'b1);
      frame(3'h1, 10'h274, 10'h000, 1'b0, 1'b1, 11'h00A, 1'b0);
      frame(3'h1, 10'h274, 10'h000, 1'b1, 1'b1, 11'h00A, 1'b1);
      frame(3'h1, 10'h200, 10'h3A5, 1'b0, 1'b1, 11'h00A, 1'b0);
      frame(3'h1, 10'h274, 10'h3A5, 1'b0, 1'b1, 11'h005, 1'b0);
      frame(3'h1, 10'h274, 10'h3A5, 1'b1, 1'b0, 11'h00A, 1'b0);
      results();
   end
endmodule
